// ---- core/dpw_wiper_ctrl.sv ----
// Overview of operation
// - slave address is 01010, then pin one, pin zero; last bit is read/write
// - serial port runs up to 400 kHz fast mode, also standard mode
// - nonvolatile programming starts only at STOP, lasting typically 10 ms
// - pulses on clock and data narrower than 50 ns are ignored
// - exactly one of default, table, or table adder mode is active
// - default mode: host writes wiper and stored initial value over serial port
// - table modes: wiper follows the previous measured temperature, one conversion behind
// - tap decoded straight from 7-bit wiper value 0 to 127
// - after power-up, nonvolatile values are copied to working registers
// - control register two bit 0 high puts device in standby
// - update bit clear: default; set with adder clear: table; both: adder
// - power-up loads stored initial value into the wiper register
// - power-up recall finishes within 5 ms
// - table modes: each conversion loads wiper from the selected table entry; adder mode adds the initial value, saturating at 127
`timescale 1ns/1ps
`include "dpw_defines.svh"
module dpw_wiper_ctrl #(
   parameter int NV_WRITE_CYC = `DPW_NV_WRITE_CYC,
   parameter int RECALL_CYC   = `DPW_RECALL_CYC,
   parameter int GLITCH_CYC   = `DPW_GLITCH_CYC
) (
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   input  wire logic                  scl_i,
   input  wire logic                  sda_i,
   output wire logic                  sda_o,
   output wire logic                  sda_oe,
   input  wire logic                  addr_select_pin_zero,
   input  wire logic                  addr_select_pin_one,
   input  wire logic [7:0]            temp_value,
   input  wire logic [7:0]            vcc_value,
   input  wire logic                  temp_valid,
   output wire logic [6:0]            wiper_pos,
   output wire logic [127:0]          tap_select,
   output wire dpw_pkg::dpw_mode_type mode,
   output wire logic                  standby,
   output wire logic                  nv_busy,
   output wire logic                  recall_busy
);
   import dpw_pkg::*;

   generate
      if (NV_WRITE_CYC < 1 || RECALL_CYC < 1 || RECALL_CYC > `DPW_RECALL_CYC) begin : g_chk
         $error("timing parameters out of range");
      end
   endgenerate

   dpw_line_if scl_line ();
   dpw_line_if sda_line ();
   assign scl_line.raw = scl_i;
   assign sda_line.raw = sda_i;

   // both lines share one filter width so start/stop ordering is kept
   dpw_glitch_filter #(.GLITCH_CYC(GLITCH_CYC)) u_scl_filt (
      .core_clk (core_clk),
      .reset    (reset),
      .line     (scl_line.filt)
   );
   dpw_glitch_filter #(.GLITCH_CYC(GLITCH_CYC)) u_sda_filt (
      .core_clk (core_clk),
      .reset    (reset),
      .line     (sda_line.filt)
   );

   dpw_state_rec_type s_q, s_d;
   dpw_mode_type      mode_c;
   logic              start_c;
   logic              stop_c;
   logic              addr_hit_c;
   logic [7:0]        rd_c;
   logic [5:0]        tbl_idx_c;
   logic [7:0]        tbl_val_c;
   logic [7:0]        sum_c;
   logic signed [9:0] tshift_c;

   // mode from the two control bits
   always_comb begin
      if (!s_q.cr1[`DPW_CR1_UPDATE]) begin
         mode_c = DPW_MODE_DEFAULT;
      end else if (!s_q.cr1[`DPW_CR1_ADDER]) begin
         mode_c = DPW_MODE_TABLE;
      end else begin
         mode_c = DPW_MODE_TABLE_ADDER;
      end
   end

   // bus conditions: data moves while clock is high
   assign start_c = sda_line.fall & scl_line.level;
   assign stop_c  = sda_line.rise & scl_line.level;

   // address compare against live pin levels; busy device stays silent
   assign addr_hit_c = (s_q.sh[7:1] == {`DPW_ADDR_FIXED, s_q.pin_sync})
                       && (s_q.nv_cnt == 32'h0) && (s_q.recall_cnt == 32'h0);

   // table index: 4 C per entry, clamped at both ends
   always_comb begin
      tshift_c = $signed({{2{s_q.temp[7]}}, s_q.temp}) + `DPW_TABLE_TEMP_BASE;
      if (tshift_c < 10'sd0) begin
         tbl_idx_c = 6'h00;
      end else if (tshift_c[9:2] > 8'(`DPW_TABLE_ENTRIES - 1)) begin
         tbl_idx_c = 6'(`DPW_TABLE_ENTRIES - 1);
      end else begin
         tbl_idx_c = tshift_c[7:2];
      end
      tbl_val_c = s_q.table_mem[tbl_idx_c];
      sum_c     = {1'b0, s_q.init_value} + tbl_val_c;
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_c = 8'h00;
      case (s_q.ptr)
         `DPW_OFS_WIPER_INIT: begin
            rd_c = (mode_c == DPW_MODE_DEFAULT) ? {1'b0, s_q.wiper} : {1'b0, s_q.init_value};
         end
         `DPW_OFS_CTRL_ZERO:  rd_c = s_q.cr0;
         `DPW_OFS_CTRL_ONE:   rd_c = s_q.cr1;
         `DPW_OFS_TABLE_ADDR: rd_c = s_q.table_addr;
         `DPW_OFS_WIPER:      rd_c = {1'b0, s_q.wiper};
         `DPW_OFS_CTRL_TWO:   rd_c = s_q.cr2;
         `DPW_OFS_TEMP:       rd_c = s_q.temp;
         `DPW_OFS_VCC:        rd_c = s_q.vcc;
         default: begin
            if (s_q.ptr >= `DPW_OFS_TABLE_FIRST && s_q.ptr <= `DPW_OFS_TABLE_LAST) begin
               rd_c = s_q.table_mem[6'(s_q.ptr - `DPW_OFS_TABLE_FIRST)];
            end
         end
      endcase
   end

   always_comb begin
      s_d          = s_q;
      s_d.pin_meta = {addr_select_pin_one, addr_select_pin_zero};
      s_d.pin_sync = s_q.pin_meta;
      s_d.vcc      = vcc_value;
      if (s_q.recall_cnt != 32'h0) begin
         s_d.recall_cnt = s_q.recall_cnt - 32'h1;  // recall window
      end
      if (s_q.nv_cnt != 32'h0) begin
         s_d.nv_cnt = s_q.nv_cnt - 32'h1;
      end
      // conversion result drives the wiper in table modes
      if (temp_valid) begin
         s_d.temp = temp_value;
      end
      if (temp_valid && mode_c != DPW_MODE_DEFAULT && s_q.recall_cnt == 32'h0) begin
         s_d.table_addr = {2'b00, tbl_idx_c};
         if (mode_c == DPW_MODE_TABLE_ADDER) begin
            s_d.wiper = sum_c[7] ? `DPW_WIPER_MAX : sum_c[6:0];
         end else begin
            s_d.wiper = tbl_val_c[6:0];
         end
      end

      case (s_q.st)
         DPW_ST_RX: begin
            if (scl_line.rise) begin
               s_d.sh  = {s_q.sh[6:0], sda_line.level};
               s_d.cnt = s_q.cnt + 4'h1;
            end else if (scl_line.fall && s_q.cnt == 4'h8) begin
               s_d.cnt   = 4'h0;
               s_d.st    = DPW_ST_ACK;
               s_d.drive = 1'b1;
               case (s_q.kind)
                  DPW_BYTE_ADDR: begin
                     s_d.rw = s_q.sh[0];
                     if (!addr_hit_c) begin
                        s_d.st    = DPW_ST_IDLE;  // no answer, line stays released
                        s_d.drive = 1'b0;
                     end
                  end
                  DPW_BYTE_PTR: s_d.ptr = s_q.sh;
                  default: begin
                     s_d.ptr = s_q.ptr + 8'h01;
                     // host writes over the serial port
                     case (s_q.ptr)
                        `DPW_OFS_WIPER_INIT: begin
                           if (mode_c == DPW_MODE_DEFAULT) begin
                              s_d.wiper = s_q.sh[6:0];
                           end
                           if (!s_q.cr0[`DPW_CR0_SHADOW_ONLY]) begin
                              s_d.init_value = s_q.sh[6:0];
                              s_d.nv_pend    = 1'b1;
                           end
                        end
                        `DPW_OFS_CTRL_ZERO: s_d.cr0 = s_q.sh;
                        `DPW_OFS_CTRL_ONE: begin
                           s_d.cr1     = s_q.sh;
                           s_d.nv_pend = 1'b1;
                        end
                        `DPW_OFS_TABLE_ADDR: s_d.table_addr = s_q.sh;
                        `DPW_OFS_WIPER: begin
                           if (mode_c != DPW_MODE_DEFAULT) begin
                              s_d.wiper = s_q.sh[6:0];
                           end
                        end
                        `DPW_OFS_CTRL_TWO: s_d.cr2 = s_q.sh;
                        default: begin
                           if (s_q.ptr >= `DPW_OFS_TABLE_FIRST
                               && s_q.ptr <= `DPW_OFS_TABLE_LAST) begin
                              s_d.table_mem[6'(s_q.ptr - `DPW_OFS_TABLE_FIRST)] = s_q.sh;
                              s_d.nv_pend = 1'b1;
                           end
                        end
                     endcase
                  end
               endcase
            end
         end
         DPW_ST_ACK: begin
            if (scl_line.fall) begin
               s_d.drive = 1'b0;
               if (s_q.kind == DPW_BYTE_ADDR && s_q.rw) begin
                  s_d.st    = DPW_ST_TX;
                  s_d.sh    = rd_c;
                  s_d.drive = ~rd_c[7];
                  s_d.ptr   = s_q.ptr + 8'h01;
               end else begin
                  s_d.st   = DPW_ST_RX;
                  s_d.kind = (s_q.kind == DPW_BYTE_ADDR) ? DPW_BYTE_PTR : DPW_BYTE_DATA;
               end
            end
         end
         DPW_ST_TX: begin
            if (scl_line.fall) begin
               s_d.cnt = s_q.cnt + 4'h1;
               if (s_q.cnt == 4'h7) begin
                  s_d.st    = DPW_ST_RACK;
                  s_d.cnt   = 4'h0;
                  s_d.drive = 1'b0;
               end else begin
                  s_d.sh    = {s_q.sh[6:0], 1'b0};
                  s_d.drive = ~s_q.sh[6];
               end
            end
         end
         DPW_ST_RACK: begin
            if (scl_line.rise) begin
               s_d.master_ack = ~sda_line.level;
            end else if (scl_line.fall) begin
               if (s_q.master_ack) begin
                  s_d.st    = DPW_ST_TX;
                  s_d.sh    = rd_c;
                  s_d.drive = ~rd_c[7];
                  s_d.ptr   = s_q.ptr + 8'h01;
               end else begin
                  s_d.st = DPW_ST_IDLE;
               end
            end
         end
         default: ;
      endcase

      // start and stop override any byte in flight
      if (start_c) begin
         s_d.st    = DPW_ST_RX;
         s_d.kind  = DPW_BYTE_ADDR;
         s_d.cnt   = 4'h0;
         s_d.drive = 1'b0;
      end else if (stop_c) begin
         s_d.st    = DPW_ST_IDLE;
         s_d.drive = 1'b0;
         if (s_q.nv_pend) begin
            s_d.nv_pend = 1'b0;
            s_d.nv_cnt  = 32'(NV_WRITE_CYC);  // programming begins only here
         end
      end

      // straight decode, one switch per tap
      s_d.tap = 128'h0;
      s_d.tap[s_q.wiper] = 1'b1;
   end

   // reset is power-on: stored values come back, wiper takes the initial value
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q            <= '0;
         s_q.st         <= DPW_ST_IDLE;
         s_q.kind       <= DPW_BYTE_ADDR;
         s_q.init_value <= `DPW_INIT_VALUE_RST;
         s_q.wiper      <= `DPW_INIT_VALUE_RST;
         s_q.cr0        <= `DPW_CTRL_RST;
         s_q.cr1        <= `DPW_CTRL_RST;
         s_q.cr2        <= `DPW_CTRL_RST;
         s_q.table_mem  <= {`DPW_TABLE_ENTRIES{`DPW_TABLE_RST}};
         s_q.recall_cnt <= 32'(RECALL_CYC);
         s_q.pin_meta   <= 2'h0;
         s_q.pin_sync   <= 2'h0;
         s_q.tap        <= 128'h0;
      end else begin
         s_q <= s_d;
      end
   end

   // open drain: only ever pull low
   assign sda_o       = 1'b0;
   assign sda_oe      = s_q.drive;
   assign wiper_pos   = s_q.wiper;
   assign tap_select  = s_q.tap;
   assign mode        = mode_c;
   assign standby     = s_q.cr2[`DPW_CR2_STANDBY];
   assign nv_busy     = (s_q.nv_cnt != 32'h0);
   assign recall_busy = (s_q.recall_cnt != 32'h0);
endmodule : dpw_wiper_ctrl

// ---- core/dpw_defines.svh ----
`ifndef DPW_DEFINES_SVH
`define DPW_DEFINES_SVH

// clock
`define DPW_CLK_PERIOD_PS      8000

// slave address: fixed upper bits, then the two address select pins
`define DPW_ADDR_FIXED         5'b01010

// timing figures in their own units
`define DPW_GLITCH_NS          50
`define DPW_NV_WRITE_MS        10
`define DPW_RECALL_MS          5

// derived cycle counts: suppression width rounds up, the others round down
// long counts go through ns so every product stays inside 32 bits
`define DPW_GLITCH_CYC   ((`DPW_GLITCH_NS * 1000 + `DPW_CLK_PERIOD_PS - 1) / `DPW_CLK_PERIOD_PS)
`define DPW_NV_WRITE_CYC (`DPW_NV_WRITE_MS * 1000000 / (`DPW_CLK_PERIOD_PS / 1000))
`define DPW_RECALL_CYC   (`DPW_RECALL_MS * 1000000 / (`DPW_CLK_PERIOD_PS / 1000))

// memory map offsets
`define DPW_OFS_WIPER_INIT     8'h00
`define DPW_OFS_CTRL_ZERO      8'h02
`define DPW_OFS_CTRL_ONE       8'h03
`define DPW_OFS_TABLE_ADDR     8'h08
`define DPW_OFS_WIPER          8'h09
`define DPW_OFS_CTRL_TWO       8'h0a
`define DPW_OFS_TEMP           8'h0c
`define DPW_OFS_VCC            8'h0e
`define DPW_OFS_TABLE_FIRST    8'h80
`define DPW_OFS_TABLE_LAST     8'ha3

// field positions
`define DPW_CR0_SHADOW_ONLY    7
`define DPW_CR1_UPDATE         0
`define DPW_CR1_ADDER          1
`define DPW_CR2_STANDBY        0

// reset and factory values
`define DPW_INIT_VALUE_RST     7'h40
`define DPW_CTRL_RST           8'h00
`define DPW_TABLE_RST          8'h00

// table geometry: entry 0 covers everything up to -37 C, 4 C per entry
`define DPW_TABLE_ENTRIES      36
`define DPW_TABLE_TEMP_BASE    10'sh028
`define DPW_WIPER_MAX          7'h7f

`endif

// ---- core/dpw_pkg.sv ----
package dpw_pkg;

   typedef enum logic [1:0] {
      DPW_MODE_DEFAULT,
      DPW_MODE_TABLE,
      DPW_MODE_TABLE_ADDER
   } dpw_mode_type;

   typedef enum logic [2:0] {
      DPW_ST_IDLE,
      DPW_ST_RX,
      DPW_ST_ACK,
      DPW_ST_TX,
      DPW_ST_RACK
   } dpw_state_type;

   typedef enum logic [1:0] {
      DPW_BYTE_ADDR,
      DPW_BYTE_PTR,
      DPW_BYTE_DATA
   } dpw_byte_type;

   typedef struct packed {
      logic [1:0]  meta;
      logic [1:0]  sync;
      logic [7:0]  cnt;
      logic        level;
      logic        rise;
      logic        fall;
   } dpw_filt_type;

   typedef struct packed {
      dpw_state_type    st;
      dpw_byte_type     kind;
      logic [3:0]       cnt;
      logic [7:0]       sh;
      logic             rw;
      logic             master_ack;
      logic             drive;
      logic [7:0]       ptr;
      logic [6:0]       wiper;
      logic [6:0]       init_value;
      logic [7:0]       cr0;
      logic [7:0]       cr1;
      logic [7:0]       cr2;
      logic [7:0]       table_addr;
      logic [7:0]       temp;
      logic [7:0]       vcc;
      logic [35:0][7:0] table_mem;
      logic             nv_pend;
      logic [31:0]      nv_cnt;
      logic [31:0]      recall_cnt;
      logic [1:0]       pin_meta;
      logic [1:0]       pin_sync;
      logic [127:0]     tap;
   } dpw_state_rec_type;

endpackage : dpw_pkg

// ---- core/dpw_line_if.sv ----
`timescale 1ns/1ps
// one filtered serial line: raw pin in, clean level and edge pulses out
interface dpw_line_if;
   logic raw;
   logic level;
   logic rise;
   logic fall;
   modport filt (input raw, output level, output rise, output fall);
   modport user (output raw, input level, input rise, input fall);
endinterface : dpw_line_if

// ---- core/dpw_glitch_filter.sv ----
`timescale 1ns/1ps
`include "dpw_defines.svh"
module dpw_glitch_filter #(
   parameter int GLITCH_CYC = `DPW_GLITCH_CYC
) (
   input  wire logic core_clk,
   input  wire logic reset,
   dpw_line_if.filt  line
);
   import dpw_pkg::*;

   dpw_filt_type s_q, s_d;

   generate
      if (GLITCH_CYC < 1 || GLITCH_CYC > 255) begin : g_chk
         $error("glitch filter width out of range");
      end
   endgenerate

   // level moves only after the synced input disagrees for a full width
   always_comb begin
      s_d      = s_q;
      s_d.rise = 1'b0;
      s_d.fall = 1'b0;
      s_d.meta = {s_q.meta[0], line.raw};
      s_d.sync = {s_q.sync[0], s_q.meta[1]};   // meta stage read by the second flop only
      if (s_q.sync[1] == s_q.level) begin
         s_d.cnt = 8'h00;                       // narrow pulse never completes
      end else if (s_q.cnt == 8'(GLITCH_CYC - 1)) begin
         s_d.cnt   = 8'h00;
         s_d.level = s_q.sync[1];
         s_d.rise  = s_q.sync[1];
         s_d.fall  = ~s_q.sync[1];
      end else begin
         s_d.cnt = s_q.cnt + 8'h01;
      end
   end

   // idle bus is high, so filtered level resets high
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '{meta: 2'h3, sync: 2'h3, cnt: 8'h00, level: 1'b1, rise: 1'b0, fall: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign line.level = s_q.level;
   assign line.rise  = s_q.rise;
   assign line.fall  = s_q.fall;
endmodule : dpw_glitch_filter

// ---- test/dpw_wiper_monitor.sv ----
`timescale 1ns/1ps
module dpw_wiper_monitor #(
   parameter int NV_WRITE_CYC = 200,
   parameter int RECALL_CYC   = 20
) (
   input wire logic                  core_clk,
   input wire logic                  reset,
   input wire logic                  scl_i,
   input wire logic                  sda_i,
   input wire logic                  sda_oe,
   input wire logic                  temp_valid,
   input wire logic [6:0]            wiper_pos,
   input wire logic [127:0]          tap_select,
   input wire dpw_pkg::dpw_mode_type mode,
   input wire logic                  standby,
   input wire logic                  nv_busy,
   input wire logic                  recall_busy
);
   import dpw_pkg::*;
   logic [31:0] nv_run_q;
   logic [31:0] rc_run_q;
   // run lengths of the busy windows, too long for a repetition
   always_ff @(posedge core_clk) begin
      if (reset) begin
         nv_run_q <= 32'h0;
         rc_run_q <= 32'h0;
      end else begin
         nv_run_q <= nv_busy ? nv_run_q + 32'h1 : 32'h0;
         rc_run_q <= recall_busy ? rc_run_q + 32'h1 : rc_run_q;
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   tap_onehot_a:
      assert property (!$past(reset) |-> tap_select == (128'h1 << $past(wiper_pos)))
      else $error("tap select off wiper");
   recall_start_a:
      assert property ($fell(reset) |-> recall_busy)
      else $error("no recall after reset");
   recall_max_a:
      assert property (rc_run_q <= RECALL_CYC)
      else $error("recall too long");
   nv_stop_a:
      assert property ($rose(nv_busy) |-> scl_i && sda_i && !$past(sda_i, 20))
      else $error("write cycle without stop");
   nv_max_a:
      assert property (nv_run_q <= NV_WRITE_CYC)
      else $error("write cycle too long");
   drive_idle_a:
      assert property ($rose(sda_oe) |-> !nv_busy && !recall_busy)
      else $error("data line driven while busy");
   standby_low_a:
      assert property ($changed(standby) |-> !scl_i)
      else $error("standby changed outside a write");
   wiper_hold_a:
      assert property (mode == DPW_MODE_DEFAULT && temp_valid |=> $stable(wiper_pos))
      else $error("wiper moved by temperature");
   cover property ($rose(nv_busy));
   cover property (mode == DPW_MODE_TABLE_ADDER);
   cover property ($rose(standby));
endmodule : dpw_wiper_monitor

// ---- test/dpw_i2c_master.sv ----
`timescale 1ns/1ps
module dpw_i2c_master (
   input  wire logic core_clk,
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_low
);
   int q      = 82;
   int glitch = 0;
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wt
   // a quarter bit between edges keeps low and high above the minimum
   task automatic start;
      sda_low <= 1'b0;
      wt(q);
      scl <= 1'b1;
      wt(q);
      sda_low <= 1'b1;
      wt(q);
      scl <= 1'b0;
      wt(q);
   endtask : start
   task automatic stop;
      sda_low <= 1'b1;
      wt(q);
      scl <= 1'b1;
      wt(q);
      sda_low <= 1'b0;
      wt(q);
   endtask : stop
   task automatic put_bit(input logic b, output logic r);
      sda_low <= !b;
      // narrow clock spike, only when the bench asks for it
      if (glitch != 0) begin
         wt(20);
         scl <= 1'b1;
         wt(5);
         scl <= 1'b0;
         glitch = 0;
      end
      wt(q);
      scl <= 1'b1;
      wt(q);
      r = sda_wire;
      wt(q);
      scl <= 1'b0;
      wt(q);
   endtask : put_bit
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(d[i], r);
      put_bit(1'b1, r);
      ack = !r;
   endtask : put_byte
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, r);
         d[i] = r;
      end
      put_bit(last, r);
   endtask : get_byte
endmodule : dpw_i2c_master

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import dpw_pkg::*;
   localparam int NV_WRITE_CYC = 3500;
   localparam int RECALL_CYC   = 20;
   logic         core_clk   = 1'b0;
   logic         reset      = 1'b1;
   logic         pin_zero   = 1'b0;
   logic         pin_one    = 1'b1;
   logic [7:0]   temp_value = 8'hdc;
   logic         temp_valid = 1'b0;
   logic         scl;
   logic         mst_low;
   logic         sda_o;
   logic         sda_oe;
   logic [6:0]   wiper_pos;
   logic [127:0] tap_select;
   dpw_mode_type mode;
   logic         standby;
   logic         nv_busy;
   logic         recall_busy;
   wire          sda_wire;
   int           fail_count   = 0;
   int           total_checks = 0;
   // pulled-up open-drain data line
   assign sda_wire = !(mst_low || (sda_oe && !sda_o));
   always #4 core_clk = ~core_clk;
   dpw_wiper_ctrl #(.NV_WRITE_CYC(NV_WRITE_CYC), .RECALL_CYC(RECALL_CYC)) dut_u (
      .core_clk(core_clk), .reset(reset), .scl_i(scl), .sda_i(sda_wire),
      .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_pin_zero(pin_zero),
      .addr_select_pin_one(pin_one), .temp_value(temp_value), .vcc_value(8'h80),
      .temp_valid(temp_valid), .wiper_pos(wiper_pos), .tap_select(tap_select),
      .mode(mode), .standby(standby), .nv_busy(nv_busy), .recall_busy(recall_busy));
   dpw_i2c_master mst_u (
      .core_clk(core_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(mst_low));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wait_sig(ref logic sig, input logic lvl, input int lim, input string what);
      int n;
      n = 0;
      while (sig !== lvl && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      chk(what, lvl, sig);
      if (sig !== lvl) complete_run();
   endtask : wait_sig
   task automatic nv_cycle;
      wait_sig(nv_busy, 1'b1, 40, "write cycle start");
      wait_sig(nv_busy, 1'b0, NV_WRITE_CYC + 2, "write cycle end");
   endtask : nv_cycle
   task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data);
      logic ack;
      mst_u.start();
      mst_u.put_byte({5'h0a, pin_one, pin_zero, 1'b0}, ack);
      chk("address ack", 1'b1, ack);
      mst_u.put_byte(ptr, ack);
      chk("pointer ack", 1'b1, ack);
      mst_u.put_byte(data, ack);
      chk("data ack", 1'b1, ack);
      chk("busy before stop", 1'b0, nv_busy);
      mst_u.stop();
   endtask : write_reg
   task automatic temp_pulses;
      repeat (2) begin
         @(posedge core_clk) temp_valid <= 1'b1;
         @(posedge core_clk) temp_valid <= 1'b0;
      end
      repeat (3) @(posedge core_clk);
   endtask : temp_pulses
   task automatic test_reset;
      chk("recall busy", 1'b1, recall_busy);
      chk("wiper at power-up", 7'h40, wiper_pos);
      chk("mode at power-up", DPW_MODE_DEFAULT, mode);
      wait_sig(recall_busy, 1'b0, RECALL_CYC + 2, "recall end");
      chk("tap at power-up", 128'h1 << 64, tap_select);
      temp_pulses();
      chk("default ignores temp", 7'h40, wiper_pos);
      $display("test reset done");
   endtask : test_reset
   task automatic test_address;
      logic ack;
      mst_u.start();
      mst_u.put_byte({5'h0a, pin_zero, pin_one, 1'b0}, ack);
      chk("swapped pin address", 1'b0, ack);
      mst_u.stop();
      // slower standard-mode master
      mst_u.q = 313;
      mst_u.start();
      mst_u.put_byte({5'h0a, pin_one, pin_zero, 1'b0}, ack);
      chk("slow master ack", 1'b1, ack);
      mst_u.stop();
      mst_u.q = 82;
      $display("test address done");
   endtask : test_address
   task automatic test_wiper;
      logic ack;
      write_reg(8'h00, 8'hff);
      chk("wiper top", 7'h7f, wiper_pos);
      chk("tap top", 128'h1 << 127, tap_select);
      wait_sig(nv_busy, 1'b1, 40, "write cycle start");
      mst_u.start();
      mst_u.put_byte({5'h0a, pin_one, pin_zero, 1'b0}, ack);
      chk("ack while writing", 1'b0, ack);
      mst_u.stop();
      wait_sig(nv_busy, 1'b0, NV_WRITE_CYC, "write cycle end");
      $display("test wiper done");
   endtask : test_wiper
   task automatic test_glitch_read;
      logic       ack;
      logic [7:0] d;
      mst_u.glitch = 1;
      write_reg(8'h00, 8'h10);
      chk("wiper after spike", 7'h10, wiper_pos);
      nv_cycle();
      mst_u.start();
      mst_u.put_byte({5'h0a, pin_one, pin_zero, 1'b0}, ack);
      mst_u.put_byte(8'h00, ack);
      mst_u.start();
      mst_u.put_byte({5'h0a, pin_one, pin_zero, 1'b1}, ack);
      chk("read address ack", 1'b1, ack);
      mst_u.get_byte(1'b1, d);
      mst_u.stop();
      chk("wiper read back", 8'h10, d);
      $display("test glitch read done");
   endtask : test_glitch_read
   task automatic test_modes;
      // -36 C falls in the second table entry
      write_reg(8'h81, 8'h25);
      nv_cycle();
      write_reg(8'h03, 8'h01);
      nv_cycle();
      chk("table mode", DPW_MODE_TABLE, mode);
      temp_pulses();
      chk("table wiper", 7'h25, wiper_pos);
      write_reg(8'h03, 8'h03);
      nv_cycle();
      chk("adder mode", DPW_MODE_TABLE_ADDER, mode);
      temp_pulses();
      chk("adder wiper", 7'h35, wiper_pos);
      $display("test modes done");
   endtask : test_modes
   task automatic test_standby;
      write_reg(8'h0a, 8'h01);
      chk("standby", 1'b1, standby);
      repeat (40) @(posedge core_clk);
      chk("no write cycle", 1'b0, nv_busy);
      $display("test standby done");
   endtask : test_standby
   initial begin
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      test_reset();
      test_address();
      test_wiper();
      test_glitch_read();
      test_modes();
      test_standby();
      complete_run();
   end
endmodule : testbench
bind dpw_wiper_ctrl dpw_wiper_monitor #(
   .NV_WRITE_CYC(NV_WRITE_CYC), .RECALL_CYC(RECALL_CYC)
) mon_u (
   .core_clk(core_clk), .reset(reset), .scl_i(scl_i), .sda_i(sda_i),
   .sda_oe(sda_oe), .temp_valid(temp_valid), .wiper_pos(wiper_pos),
   .tap_select(tap_select), .mode(mode), .standby(standby),
   .nv_busy(nv_busy), .recall_busy(recall_busy));
